// ### design/hbw_host_port.sv
// host bus port: 32/16-bit width, half-word pairing and word swap
// How it works
// - the data bus runs 32 or 16 bits wide as picked by the width strap pin.
// - the strapped width reads back in bit 2 of the hardware configuration register.
// - either half may come first so long as the second targets the other half.
// - a second write to the same half is dropped.
// - two reads of the same half give invalid data and the read pairing restarts.
// - in 16-bit mode the upper sixteen data lines are never driven.
// - in 32-bit mode the swap control is ignored and lanes map straight.
// - in 16-bit mode the swap control applies to registers and FIFOs alike.
// - with swap not all ones, half select 0 is the low half and 1 the high half.
// - with swap all ones, half select 0 is the high half and 1 the low half.
// - the core moves the low half of each double word to and from the network first.
// Timing notes
// the strap is sampled at the first clock after reset release and held until the next reset.
// a wide write reaches the core one cycle after it is taken; a narrow pair two cycles after its second half.
// read data and lane enables follow a read by one cycle; the enables stand for that cycle alone.
// a narrow read fetches the whole word with the first half and answers the second half from that copy,
// so a core word that changes between the two halves is seen as it stood at the first half.
// a same-half read answers zero and a same-half write is dropped; both raise read_restart for one cycle.
// the swap control counts only at the exact all-ones value; any other value keeps the default map.
// writes to the configuration word are ignored, since the width comes from the strap alone.
`timescale 1ns/1ps
module hbw_host_port (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    // strap and host bus
    input  wire logic                   width_strap_pin,
    input  wire logic [7:0]             host_addr,
    input  wire logic                   host_wr,
    input  wire logic                   host_rd,
    input  wire logic [31:0]            host_wdata,
    output logic [31:0]                 host_rdata,
    output logic [31:0]                 host_data_oe,
    // core side
    output logic                        core_wr,
    output hbw_pkg::hbw_word_s          core_wword,
    output logic                        core_rd,
    output logic [7:0]                  core_raddr,
    input  wire logic [31:0]            core_rdata,
    // status
    output logic                        bus_is_16,
    output logic                        read_restart
);
    // mode capture
    logic               strap_taken_q;
    logic               strap_taken_d;
    logic               is16_q;
    logic               is16_d;

    // write path and swap control
    logic [31:0]        swap_q;
    logic [31:0]        swap_d;
    logic               cwr_q;
    logic               cwr_d;
    hbw_pkg::hbw_word_s cword_q;
    hbw_pkg::hbw_word_s cword_d;
    logic [7:0]         wr_addr_q;
    logic [7:0]         wr_addr_d;

    // read path
    logic [31:0]        rdata_q;
    logic [31:0]        rdata_d;
    logic               crd_q;
    logic               crd_d;
    logic [7:0]         craddr_q;
    logic [7:0]         craddr_d;
    logic               rd_open_q;
    logic               rd_open_d;
    logic               rd_half_q;
    logic               rd_half_d;
    logic [31:0]        rd_word_q;
    logic [31:0]        rd_word_d;
    logic               restart_q;
    logic               restart_d;

    // lane enables
    logic [31:0]        oe_q;
    logic [31:0]        oe_d;

    // combinational helpers
    logic               swap_on;
    logic               sel_high;
    logic               pair_done;
    logic               pair_same;
    logic [31:0]        pair_word;
    logic               half_wr;
    logic [7:0]         word_addr;
    logic [31:0]        local_rdata;
    logic               local_hit;
    logic [31:0]        fetch_word;
    logic [15:0]        fetch_half;
    logic               commit_go;
    logic [7:0]         commit_addr;
    logic [31:0]        commit_data;

    // swap only counts in 16-bit mode and only for the all-ones value
    // swap ignored wide
    assign swap_on   = is16_q && (swap_q == hbw_pkg::HBW_SWAP_ALL_ONES);
    assign sel_high  = host_addr[1] ^ swap_on;
    assign word_addr = {host_addr[7:2], 2'b00};
    assign half_wr   = is16_q && host_wr;
    // a read answers from the local registers when the address matches them, else from the core
    assign fetch_word = local_hit ? local_rdata : core_rdata;
    assign fetch_half = sel_high ? fetch_word[31:16] : fetch_word[15:0];

    hbw_half_pair u_wr_pair (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .strobe    (half_wr),
        .half_high (sel_high),
        .half_data (host_wdata[15:0]),
        .done      (pair_done),
        .same_half (pair_same),
        .word      (pair_word)
    );

    // local registers: configuration readback and swap control
    always_comb begin
        local_hit   = 1'b1;
        local_rdata = 32'h0000_0000;
        case (word_addr)
            hbw_pkg::HBW_CONF_OFS: begin
                local_rdata[hbw_pkg::HBW_CFG_WIDTH_BIT] = ~is16_q;
            end
            hbw_pkg::HBW_SWAP_OFS: begin
                // the swap control reads back whole, in either width
                local_rdata = swap_q;
            end
            default: begin
                // every other word belongs to the core
                local_hit = 1'b0;
            end
        endcase
    end

    // strap is caught at the first clock after reset release, not by the reset itself
    always_comb begin
        strap_taken_d = 1'b1;
        is16_d        = is16_q;
        if (!strap_taken_q) begin
            is16_d = ~width_strap_pin;
        end
    end

    // one word to commit per cycle: a wide write, or a finished narrow pair
    always_comb begin
        commit_go   = 1'b0;
        commit_addr = wr_addr_q;
        commit_data = pair_word;
        if (!is16_q && host_wr) begin
            commit_go   = 1'b1;
            commit_addr = word_addr;
            commit_data = host_wdata;
        end else if (pair_done) begin
            commit_go   = 1'b1;
        end
    end

    // write side: a committed word lands in the swap control, is dropped for the
    // read-only configuration word, or goes to the core
    always_comb begin
        swap_d    = swap_q;
        cwr_d     = 1'b0;
        cword_d   = cword_q;
        wr_addr_d = wr_addr_q;
        if (half_wr) begin
            wr_addr_d = word_addr;
        end
        if (commit_go) begin
            cword_d = '{addr: commit_addr, data: commit_data};
            if (commit_addr == hbw_pkg::HBW_SWAP_OFS) begin
                swap_d = commit_data;
            end else if (commit_addr != hbw_pkg::HBW_CONF_OFS) begin
                cwr_d = 1'b1;
            end
        end
    end

    // read side: a narrow pair fetches the word at the first half and keeps a copy
    always_comb begin
        rdata_d   = rdata_q;
        crd_d     = 1'b0;
        craddr_d  = craddr_q;
        rd_open_d = rd_open_q;
        rd_half_d = rd_half_q;
        rd_word_d = rd_word_q;
        restart_d = 1'b0;
        if (host_rd) begin
            if (!is16_q) begin
                // wide read: the whole word at once
                rdata_d  = fetch_word;
                crd_d    = ~local_hit;
                craddr_d = word_addr;
            end else if (!rd_open_q) begin
                // narrow first half: fetch the word and keep it for the other half
                rd_open_d = 1'b1;
                rd_half_d = sel_high;
                crd_d     = ~local_hit;
                craddr_d  = word_addr;
                rd_word_d = fetch_word;
                rdata_d   = {16'h0000, fetch_half};
            end else if (sel_high == rd_half_q) begin
                rd_open_d = 1'b0;
                restart_d = 1'b1;
                rdata_d   = 32'h0000_0000;
            end else begin
                // narrow second half: answered from the kept copy
                rd_open_d = 1'b0;
                rdata_d   = sel_high ? {16'h0000, rd_word_q[31:16]} : {16'h0000, rd_word_q[15:0]};
            end
        end
        // a dropped same-half write is reported through the same status flop
        if (pair_same) begin
            restart_d = 1'b1;
        end
    end

    // drive enables: full bus when wide, low lanes only when narrow
    always_comb begin
        oe_d = 32'h0000_0000;
        if (host_rd) begin
            oe_d = is16_q ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        end
    end

    // mode capture registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strap_taken_q <= 1'b0;
            is16_q        <= 1'b0;
        end else begin
            strap_taken_q <= strap_taken_d;
            is16_q        <= is16_d;
        end
    end

    // write path registers; the swap control returns to its reset value with the port
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            swap_q    <= hbw_pkg::HBW_SWAP_RST;
            cwr_q     <= 1'b0;
            cword_q   <= '0;
            wr_addr_q <= 8'h00;
        end else begin
            swap_q    <= swap_d;
            cwr_q     <= cwr_d;
            cword_q   <= cword_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    // read path registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q   <= 32'h0000_0000;
            crd_q     <= 1'b0;
            craddr_q  <= 8'h00;
            rd_open_q <= 1'b0;
            rd_half_q <= 1'b0;
            rd_word_q <= 32'h0000_0000;
            restart_q <= 1'b0;
        end else begin
            rdata_q   <= rdata_d;
            crd_q     <= crd_d;
            craddr_q  <= craddr_d;
            rd_open_q <= rd_open_d;
            rd_half_q <= rd_half_d;
            rd_word_q <= rd_word_d;
            restart_q <= restart_d;
        end
    end

    // lane enable register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oe_q <= 32'h0000_0000;
        end else begin
            oe_q <= oe_d;
        end
    end

    // core sees whole words, low half is bits 15:0
    assign host_rdata   = rdata_q;
    assign host_data_oe = oe_q;
    assign core_wr      = cwr_q;
    assign core_wword   = cword_q;
    assign core_rd      = crd_q;
    assign core_raddr   = craddr_q;
    assign bus_is_16    = is16_q;
    assign read_restart = restart_q;
endmodule

// ### pkg/hbw_pkg.sv
// package for the host bus width and half-word swap port
package hbw_pkg;
    localparam int          HBW_DW            = 32;
    localparam int          HBW_HW            = 16;
    localparam int          HBW_AW            = 8;
    // register offsets (byte addresses, word aligned)
    localparam logic [7:0]  HBW_CONF_OFS      = 8'h74;
    localparam logic [7:0]  HBW_SWAP_OFS      = 8'h98;
    localparam logic [7:0]  HBW_FIFO_OFS      = 8'h00;
    localparam int          HBW_CFG_WIDTH_BIT = 2;
    localparam logic [31:0] HBW_SWAP_RST      = 32'h0000_0000;
    localparam logic [31:0] HBW_SWAP_ALL_ONES = 32'hFFFF_FFFF;

    typedef enum logic {
        HBW_HALF_LOW,
        HBW_HALF_HIGH
    } hbw_half_e;

    // one double-word access toward the core
    typedef struct packed {
        logic [HBW_AW-1:0] addr;
        logic [31:0]       data;
    } hbw_word_s;
endpackage

// ### design/hbw_half_pair.sv
// pairs two half-word accesses into one double word
`timescale 1ns/1ps
module hbw_half_pair (
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic               strobe,
    input  wire logic               half_high,
    input  wire logic [15:0]        half_data,
    output logic                    done,
    output logic                    same_half,
    output logic [31:0]             word
);
    logic        open_q,  open_d;
    logic        half_q,  half_d;
    logic [15:0] keep_q,  keep_d;
    logic        done_q,  done_d;
    logic        same_q,  same_d;
    logic [31:0] word_q,  word_d;

    // a second half that matches the first is flagged and the pair restarts
    always_comb begin
        open_d = open_q;
        half_d = half_q;
        keep_d = keep_q;
        done_d = 1'b0;
        same_d = 1'b0;
        word_d = word_q;
        if (strobe) begin
            if (!open_q) begin
                open_d = 1'b1;
                half_d = half_high;
                keep_d = half_data;
            end else if (half_high == half_q) begin
                open_d = 1'b0;
                same_d = 1'b1;
            end else begin
                open_d = 1'b0;
                done_d = 1'b1;
                word_d = half_high ? {half_data, keep_q} : {keep_q, half_data};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            open_q <= 1'b0;
            half_q <= 1'b0;
            keep_q <= 16'h0000;
            done_q <= 1'b0;
            same_q <= 1'b0;
            word_q <= 32'h0000_0000;
        end else begin
            open_q <= open_d;
            half_q <= half_d;
            keep_q <= keep_d;
            done_q <= done_d;
            same_q <= same_d;
            word_q <= word_d;
        end
    end

    assign done      = done_q;
    assign same_half = same_q;
    assign word      = word_q;
endmodule

// ### verif/hbw_host_port_monitor.sv
// checker for the host bus width port
`timescale 1ns/1ps
module hbw_host_port_monitor (
    input wire logic               core_clk,
    input wire logic               rstn,
    input wire logic               width_strap_pin,
    input wire logic [7:0]         host_addr,
    input wire logic               host_wr,
    input wire logic               host_rd,
    input wire logic [31:0]        host_wdata,
    input wire logic [31:0]        host_rdata,
    input wire logic [31:0]        host_data_oe,
    input wire logic               core_wr,
    input wire hbw_pkg::hbw_word_s core_wword,
    input wire logic               core_rd,
    input wire logic [7:0]         core_raddr,
    input wire logic [31:0]        core_rdata,
    input wire logic               bus_is_16,
    input wire logic               read_restart
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // the two internal offsets answer from the port itself, not the core
    logic plain_addr;
    assign plain_addr = host_addr != hbw_pkg::HBW_CONF_OFS && host_addr != hbw_pkg::HBW_SWAP_OFS;
    upper_off_a: assert property (bus_is_16 |-> host_data_oe[31:16] == 16'h0000 && host_rdata[31:16] == 16'h0000)
        else $error("upper lanes active in narrow mode");
    read_lanes_a: assert property (host_rd |=> host_data_oe == (bus_is_16 ? 32'h0000FFFF : 32'hFFFFFFFF))
        else $error("lane enables wrong after read");
    lanes_idle_a: assert property (!host_rd |=> host_data_oe == 32'h0000_0000)
        else $error("lanes driven without a read");
    width_bit_a: assert property (host_rd && !bus_is_16 && host_addr == hbw_pkg::HBW_CONF_OFS |=> host_rdata[2])
        else $error("width bit clear in wide mode");
    wide_write_a: assert property (host_wr && !bus_is_16 && plain_addr |=> core_wr &&
        core_wword.data == $past(host_wdata) && core_wword.addr[7:2] == $past(host_addr[7:2]))
        else $error("wide write not committed straight");
    wide_read_a: assert property (host_rd && !bus_is_16 && plain_addr |=> host_rdata == $past(core_rdata))
        else $error("wide read not straight");
    core_read_a: assert property (host_rd && !bus_is_16 && plain_addr |=> core_rd &&
        core_raddr == {$past(host_addr[7:2]), 2'b00})
        else $error("core read notice missing");
    pair_commit_a: assert property (core_wr && bus_is_16 |-> $past(host_wr, 2))
        else $error("narrow commit without second half");
    mode_steady_a: assert property ($past(rstn, 2) |-> $stable(bus_is_16))
        else $error("bus width changed outside reset");
    cover property (bus_is_16 && core_wr);
    cover property (!bus_is_16 && core_wr);
    cover property (read_restart);
endmodule
bind hbw_host_port hbw_host_port_monitor u_mon (.core_clk(core_clk), .rstn(rstn),
    .width_strap_pin(width_strap_pin), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_data_oe(host_data_oe), .core_wr(core_wr),
    .core_wword(core_wword), .core_rd(core_rd), .core_raddr(core_raddr), .core_rdata(core_rdata),
    .bus_is_16(bus_is_16), .read_restart(read_restart));

// ### verif/hbw_core_model.sv
// core side model: word store behind the host port
`timescale 1ns/1ps
module hbw_core_model (
    input wire logic               core_clk,
    input wire logic               rstn,
    input wire logic               core_wr,
    input wire hbw_pkg::hbw_word_s core_wword,
    input wire logic [7:0]         host_addr,
    output logic [31:0]            core_rdata
);
    logic [31:0] mem [64];
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 64; i++) mem[i] <= 32'h5A5A_0000 ^ 32'(i);
        end else if (core_wr) begin
            mem[core_wword.addr[7:2]] <= core_wword.data;
        end
    end
    // read data follows the address at once, as the port expects
    assign core_rdata = mem[host_addr[7:2]];
endmodule

// ### verif/hbw_host_port_tb_top.sv
// self-checking bench for the host bus width port
`timescale 1ns/1ps
module hbw_host_port_tb_top;
    logic               core_clk = 1'b0;
    logic               rstn = 1'b0;
    logic               strap = 1'b1;
    logic               host_wr = 1'b0;
    logic               host_rd = 1'b0;
    logic [7:0]         host_addr = 8'h00;
    logic [31:0]        host_wdata = 32'h0000_0000;
    logic [31:0]        host_rdata, host_data_oe, core_rdata, rd_q, oe_q, sw, d;
    logic               core_wr, core_rd, bus_is_16, read_restart, o;
    hbw_pkg::hbw_word_s core_wword;
    logic [7:0]         core_raddr, a;
    int                 seed = 9, bad_count = 0, samples_checked = 0, cycles = 0, restarts = 0, n0, i;

    hbw_host_port dut (.core_clk(core_clk), .rstn(rstn), .width_strap_pin(strap), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_data_oe(host_data_oe), .core_wr(core_wr), .core_wword(core_wword), .core_rd(core_rd),
        .core_raddr(core_raddr), .core_rdata(core_rdata), .bus_is_16(bus_is_16), .read_restart(read_restart));
    hbw_core_model u_core (.core_clk(core_clk), .rstn(rstn), .core_wr(core_wr), .core_wword(core_wword),
        .host_addr(host_addr), .core_rdata(core_rdata));

    // clock, restart pulses and the hang guard; a hang is judged a mismatch
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (read_restart === 1'b1) restarts++;
        if (cycles == 3000) begin
            bad_count++;
            $display("unexpected timeout: expected done seen hang");
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one bus cycle per falling edge; the previous read answer is kept first
    task automatic drive(input logic r, input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(negedge core_clk);
        rd_q = host_rdata;
        oe_q = host_data_oe;
        host_rd = r;
        host_wr = w;
        host_addr = ad;
        host_wdata = wd;
    endtask

    task automatic do_reset(input logic s);
        rstn = 1'b0;
        strap = s;
        sw = hbw_pkg::HBW_SWAP_RST;
        repeat (8) @(negedge core_clk);
        rstn = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask

    // which word half a half-select bit reaches under the current swap value
    function automatic logic [31:0] lane(input logic b, input logic [31:0] w);
        return {16'h0000, (b ^ (sw === hbw_pkg::HBW_SWAP_ALL_ONES)) ? w[31:16] : w[15:0]};
    endfunction

    // halves go back to back inside one double word; upper lines rest low
    task automatic wr16(input logic [7:0] ad, input logic f, input logic [31:0] w);
        drive(1'b0, 1'b1, {ad[7:2], f, 1'b0}, lane(f, w));
        drive(1'b0, 1'b1, {ad[7:2], !f, 1'b0}, lane(!f, w));
        drive(1'b0, 1'b0, ad, 32'h0000_0000);
    endtask

    task automatic rd16(input logic [7:0] ad, input logic f, input logic [31:0] w);
        drive(1'b1, 1'b0, {ad[7:2], f, 1'b0}, 32'h0000_0000);
        drive(1'b1, 1'b0, {ad[7:2], !f, 1'b0}, 32'h0000_0000);
        chk("first half", lane(f, w), rd_q);
        chk("narrow lanes", 32'h0000FFFF, oe_q);
        drive(1'b0, 1'b0, ad, 32'h0000_0000);
        chk("second half", lane(!f, w), rd_q);
    endtask

    // waits a few cycles for a commit strobe, since a narrow pair adds latency
    task automatic commit(input logic [7:0] ad, input logic [31:0] w, input logic want);
        int n;
        for (n = 0; n < 5 && core_wr !== 1'b1; n++) @(negedge core_clk);
        chk("commit seen", {31'h0, want}, {31'h0, core_wr});
        if (want) chk("commit data", w, core_wword.data);
        if (want) chk("commit addr", {26'h0, ad[7:2]}, {26'h0, core_wword.addr[7:2]});
    endtask

    initial begin
        do_reset(1'b1);
        // wide mode: width bit set, swap written but ignored
        drive(1'b1, 1'b0, hbw_pkg::HBW_CONF_OFS, 32'h0000_0000);
        drive(1'b0, 1'b1, hbw_pkg::HBW_SWAP_OFS, hbw_pkg::HBW_SWAP_ALL_ONES);
        chk("width bit", 32'h1, {31'h0, rd_q[2]});
        chk("wide lanes", 32'hFFFFFFFF, oe_q);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            a = {2'b00, 4'($random(seed)), 2'b00};
            drive(1'b0, 1'b1, a, d);
            drive(1'b0, 1'b0, a, 32'h0000_0000);
            commit(a, d, 1'b1);
            drive(1'b1, 1'b0, a, 32'h0000_0000);
            drive(1'b0, 1'b0, a, 32'h0000_0000);
            chk("wide read", d, rd_q);
        end
        $display("test wide mode done");
        do_reset(1'b0);
        // narrow mode: width bit clear, random order, swap off then set
        rd16(hbw_pkg::HBW_CONF_OFS, 1'b0, 32'h0000_0000);
        for (i = 0; i < 6; i++) begin
            if (i == 0 || i == 3) begin
                wr16(hbw_pkg::HBW_SWAP_OFS, 1'b0, i == 0 ? 32'h0FFF_FFFF : 32'hFFFF_FFFF);
                sw = i == 0 ? 32'h0FFF_FFFF : 32'hFFFF_FFFF;
                repeat (4) drive(1'b0, 1'b0, 8'h00, 32'h0000_0000);
                rd16(hbw_pkg::HBW_SWAP_OFS, 1'b0, sw);
            end
            d = $random(seed);
            a = {2'b00, 4'($random(seed)), 2'b00};
            o = 1'($random(seed));
            wr16(a, o, d);
            commit(a, d, 1'b1);
            rd16(a, !o, d);
        end
        $display("test narrow pairs done");
        // same half read twice: answer refused, pairing restarts
        n0 = restarts;
        drive(1'b1, 1'b0, {a[7:2], 2'b00}, 32'h0000_0000);
        drive(1'b1, 1'b0, {a[7:2], 2'b00}, 32'h0000_0000);
        drive(1'b0, 1'b0, a, 32'h0000_0000);
        chk("repeat read", 32'h0000_0000, rd_q);
        drive(1'b0, 1'b0, a, 32'h0000_0000);
        chk("read restart", 32'(n0 + 1), 32'(restarts));
        rd16(a, 1'b1, d);
        // same half written twice: nothing committed
        n0 = restarts;
        drive(1'b0, 1'b1, {a[7:2], 2'b00}, 32'h0000_1234);
        drive(1'b0, 1'b1, {a[7:2], 2'b00}, 32'h0000_5678);
        drive(1'b0, 1'b0, a, 32'h0000_0000);
        commit(a, d, 1'b0);
        chk("write restart", 32'(n0 + 1), 32'(restarts));
        $display("test same half done");
        report_and_stop();
    end
endmodule
